// File: include/bpwp_pkg.sv
//--------------------------------------------------------------
// Summary of operation
//--------------------------------------------------------------
// Summary of operation
// RULE_01 - Four breakpoint controls, thread mask bits 23:16
// RULE_02 - Bit 1 inverts breakpoint address compare
// RULE_03 - Bit 0 enables breakpoint, resets zero
// RULE_04 - Four data watch first addresses
// RULE_05 - Four data watch second addresses
// RULE_06 - Data watch control: thread mask, enable
// RULE_07 - Data watch bit 2 selects loads
// RULE_08 - Data watch bit 1: AND or OR
// RULE_09 - Four resource watch mask values
// RULE_10 - Four resource watch compare values
// RULE_11 - Resource watch control: thread mask, enable
// RULE_12 - Resource watch bit 1 picks condition
// RULE_13 - Breakpoint address match raises debug interrupt
// RULE_14 - Cause code 3, 4 or 5 recorded
// RULE_15 - Capture effective address or resource id
// RULE_16 - Record unit number and thread, lowest wins
// RULE_17 - Data conditions compare address registers
// RULE_18 - Resource conditions: masked equal, masked differ
package bpwp_pkg;

   //-----------------------------------------------------------
   // Geometry
   //-----------------------------------------------------------
   localparam int NUM_UNITS   = 4;
   localparam int NUM_THREADS = 8;

   //-----------------------------------------------------------
   // Register numbers
   //-----------------------------------------------------------
   localparam logic [7:0] OFS_CAUSE_RECORD = 8'h15;
   localparam logic [7:0] OFS_TRIGGER_DATA = 8'h16;
   localparam logic [7:0] OFS_IB_ADDR      = 8'h30;
   localparam logic [7:0] OFS_IB_CTRL      = 8'h40;
   localparam logic [7:0] OFS_DW_FIRST     = 8'h50;
   localparam logic [7:0] OFS_DW_SECOND    = 8'h60;
   localparam logic [7:0] OFS_DW_CTRL      = 8'h70;
   localparam logic [7:0] OFS_RW_MASK      = 8'h80;
   localparam logic [7:0] OFS_RW_VALUE     = 8'h90;
   localparam logic [7:0] OFS_RW_CTRL      = 8'h9c;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'ha0;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'ha1;

   //-----------------------------------------------------------
   // Fields and reset values
   //-----------------------------------------------------------
   localparam int ENABLE_BIT    = 0;
   localparam int CONDITION_BIT = 1;
   localparam int LOAD_BIT      = 2;
   localparam int TMASK_LSB     = 16;
   localparam int TMASK_MSB     = 23;

   localparam logic [31:0] IB_CTRL_WMASK = 32'h00ff0003;
   localparam logic [31:0] DW_CTRL_WMASK = 32'h00ff0007;
   localparam logic [31:0] RW_CTRL_WMASK = 32'h00ff0003;
   localparam logic [31:0] CAUSE_WMASK   = 32'h0003ff07;
   localparam logic [31:0] REG_RESET     = 32'h00000000;

   localparam logic [2:0] CAUSE_IB = 3'h3;
   localparam logic [2:0] CAUSE_DW = 3'h4;
   localparam logic [2:0] CAUSE_RW = 3'h5;

   localparam int IRQ_IB   = 0;
   localparam int IRQ_DW   = 1;
   localparam int IRQ_RW   = 2;
   localparam int IRQ_BITS = 3;

   //-----------------------------------------------------------
   // Carriers
   //-----------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  thread;
      logic [31:0] pc;
   } inst_obs_t;

   typedef struct packed {
      logic        valid;
      logic        is_load;
      logic [2:0]  thread;
      logic [31:0] addr;
   } mem_obs_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  thread;
      logic [31:0] res_id;
   } res_obs_t;

endpackage : bpwp_pkg

// File: rtl/breakpoint_watchpoint_unit.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module breakpoint_watchpoint_unit
   import bpwp_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire bus_req_t    bus,
   output logic [31:0]      rdata,
   input  wire inst_obs_t   inst_obs,
   input  wire mem_obs_t    mem_obs,
   input  wire res_obs_t    res_obs,
   output logic             debug_irq
);

   //-----------------------------------------------------------
   // Storage
   //-----------------------------------------------------------
   logic [31:0]          ib_addr   [NUM_UNITS];
   logic [31:0]          ib_ctrl   [NUM_UNITS];
   logic [31:0]          dw_first  [NUM_UNITS];
   logic [31:0]          dw_second [NUM_UNITS];
   logic [31:0]          dw_ctrl   [NUM_UNITS];
   logic [31:0]          rw_mask   [NUM_UNITS];
   logic [31:0]          rw_value  [NUM_UNITS];
   logic [31:0]          rw_ctrl   [NUM_UNITS];
   logic [31:0]          cause_record;
   logic [31:0]          trigger_data;
   logic [IRQ_BITS-1:0]  irq_status;
   logic [IRQ_BITS-1:0]  irq_mask;

   logic [NUM_UNITS-1:0] ib_hit;
   logic [NUM_UNITS-1:0] dw_hit;
   logic [NUM_UNITS-1:0] rw_hit;
   logic [NUM_UNITS-1:0] ib_en;
   logic [NUM_UNITS-1:0] dw_en;
   logic [NUM_UNITS-1:0] rw_en;
   logic                 any_ib;
   logic                 any_dw;
   logic                 any_rw;
   logic [31:0]          next_rdata;

   function automatic logic [1:0] lowest_index(input logic [NUM_UNITS-1:0] v);
      logic [1:0] idx;
      idx = 2'h0;
      for (int k = NUM_UNITS - 1; k >= 0; k--) begin
         if (v[k]) begin
            idx = k[1:0];
         end
      end
      return idx;
   endfunction : lowest_index

   function automatic logic sel_wr(input bus_req_t b, input logic [7:0] base,
                                   input int n);
      return b.wr && (b.addr == base + 8'(n));
   endfunction : sel_wr

   //-----------------------------------------------------------
   // Per-unit registers and comparators
   //-----------------------------------------------------------
   for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
      logic       dw_cond_a;
      logic       dw_cond_b;
      logic       dw_kind_ok;
      logic       rw_cond_a;
      logic       rw_cond_b;
      logic [7:0] ib_tmask;
      logic [7:0] dw_tmask;
      logic [7:0] rw_tmask;

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ib_addr[i] <= REG_RESET;
            ib_ctrl[i] <= REG_RESET;
         end else if (ce) begin
            if (sel_wr(bus, OFS_IB_ADDR, i)) begin
               ib_addr[i] <= bus.wdata;
            end
            if (sel_wr(bus, OFS_IB_CTRL, i)) begin
               ib_ctrl[i] <= bus.wdata & IB_CTRL_WMASK; // see RULE_01
            end
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            dw_first[i]  <= REG_RESET;
            dw_second[i] <= REG_RESET;
            dw_ctrl[i]   <= REG_RESET;
         end else if (ce) begin
            if (sel_wr(bus, OFS_DW_FIRST, i)) begin
               dw_first[i] <= bus.wdata; // see RULE_04
            end
            if (sel_wr(bus, OFS_DW_SECOND, i)) begin
               dw_second[i] <= bus.wdata; // see RULE_05
            end
            if (sel_wr(bus, OFS_DW_CTRL, i)) begin
               dw_ctrl[i] <= bus.wdata & DW_CTRL_WMASK; // see RULE_06
            end
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            rw_mask[i]  <= REG_RESET;
            rw_value[i] <= REG_RESET;
            rw_ctrl[i]  <= REG_RESET;
         end else if (ce) begin
            if (sel_wr(bus, OFS_RW_MASK, i)) begin
               rw_mask[i] <= bus.wdata; // see RULE_09
            end
            if (sel_wr(bus, OFS_RW_VALUE, i)) begin
               rw_value[i] <= bus.wdata; // see RULE_10
            end
            if (sel_wr(bus, OFS_RW_CTRL, i)) begin
               rw_ctrl[i] <= bus.wdata & RW_CTRL_WMASK; // see RULE_11
            end
         end
      end

      assign ib_tmask = ib_ctrl[i][TMASK_MSB:TMASK_LSB];
      assign dw_tmask = dw_ctrl[i][TMASK_MSB:TMASK_LSB];
      assign rw_tmask = rw_ctrl[i][TMASK_MSB:TMASK_LSB];
      assign ib_en[i] = ib_ctrl[i][ENABLE_BIT];
      assign dw_en[i] = dw_ctrl[i][ENABLE_BIT];
      assign rw_en[i] = rw_ctrl[i][ENABLE_BIT];

      // Equal or differ on the program counter
      assign ib_hit[i] = inst_obs.valid && ib_en[i]                  // see RULE_03
                      && ib_tmask[inst_obs.thread]                   // see RULE_01
                      && ((inst_obs.pc == ib_addr[i])
                          ^ ib_ctrl[i][CONDITION_BIT]);              // see RULE_02

      assign dw_cond_a  = (mem_obs.addr == dw_first[i]);             // see RULE_17
      assign dw_cond_b  = (mem_obs.addr == dw_second[i]);            // see RULE_17
      // Load bit picks loads; clear, the unit watches stores only
      assign dw_kind_ok = (mem_obs.is_load == dw_ctrl[i][LOAD_BIT]); // see RULE_07
      assign dw_hit[i]  = mem_obs.valid && dw_en[i] && dw_kind_ok
                       && dw_tmask[mem_obs.thread]                   // see RULE_06
                       && (dw_ctrl[i][CONDITION_BIT]
                           ? (dw_cond_a || dw_cond_b)
                           : (dw_cond_a && dw_cond_b));              // see RULE_08

      assign rw_cond_a = ((res_obs.res_id & rw_mask[i])
                          == (rw_value[i] & rw_mask[i]));            // see RULE_18
      assign rw_cond_b = !rw_cond_a;                                 // see RULE_18
      assign rw_hit[i] = res_obs.valid && rw_en[i]
                      && rw_tmask[res_obs.thread]                    // see RULE_11
                      && (rw_ctrl[i][CONDITION_BIT]
                          ? rw_cond_b : rw_cond_a);                  // see RULE_12
   end

   assign any_ib = |ib_hit;
   assign any_dw = |dw_hit;
   assign any_rw = |rw_hit;

   //-----------------------------------------------------------
   // Trigger record
   //-----------------------------------------------------------
   // Instruction breakpoints outrank data, data outrank resource
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cause_record <= REG_RESET;
      end else if (ce) begin
         if (any_ib) begin
            cause_record <= {14'h0, lowest_index(ib_hit), 5'h0,
                             inst_obs.thread, 5'h0, CAUSE_IB};       // see RULE_14
         end else if (any_dw) begin
            cause_record <= {14'h0, lowest_index(dw_hit), 5'h0,
                             mem_obs.thread, 5'h0, CAUSE_DW};        // see RULE_16
         end else if (any_rw) begin
            cause_record <= {14'h0, lowest_index(rw_hit), 5'h0,
                             res_obs.thread, 5'h0, CAUSE_RW};        // see RULE_14
         end else if (bus.wr && bus.addr == OFS_CAUSE_RECORD) begin
            cause_record <= bus.wdata & CAUSE_WMASK;
         end
      end
   end

   // Breakpoints leave the data record alone
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigger_data <= REG_RESET;
      end else if (ce) begin
         if (!any_ib && any_dw) begin
            trigger_data <= mem_obs.addr; // see RULE_15
         end else if (!any_ib && any_rw) begin
            trigger_data <= res_obs.res_id; // see RULE_15
         end else if (!any_ib && bus.wr && bus.addr == OFS_TRIGGER_DATA) begin
            trigger_data <= bus.wdata;
         end
      end
   end

   //-----------------------------------------------------------
   // Interrupt status and mask
   //-----------------------------------------------------------
   // A new event beats a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
      end else if (ce) begin
         irq_status <= (irq_status
                        & ~((bus.wr && bus.addr == OFS_IRQ_STATUS)
                            ? bus.wdata[IRQ_BITS-1:0] : '0))
                       | {any_rw, any_dw, any_ib};                   // see RULE_13
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_mask <= '0;
      end else if (ce && bus.wr && bus.addr == OFS_IRQ_MASK) begin
         irq_mask <= bus.wdata[IRQ_BITS-1:0];
      end
   end

   assign debug_irq = |(irq_status & irq_mask); // see RULE_13

   //-----------------------------------------------------------
   // Read port
   //-----------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0;
      if (bus.addr == OFS_CAUSE_RECORD) begin
         next_rdata = cause_record;
      end else if (bus.addr == OFS_TRIGGER_DATA) begin
         next_rdata = trigger_data;
      end else if (bus.addr == OFS_IRQ_STATUS) begin
         next_rdata = {29'h0, irq_status};
      end else if (bus.addr == OFS_IRQ_MASK) begin
         next_rdata = {29'h0, irq_mask};
      end else begin
         for (int n = 0; n < NUM_UNITS; n++) begin
            if (bus.addr == OFS_IB_ADDR + 8'(n)) next_rdata = ib_addr[n];
            if (bus.addr == OFS_IB_CTRL + 8'(n)) next_rdata = ib_ctrl[n];
            if (bus.addr == OFS_DW_FIRST + 8'(n)) next_rdata = dw_first[n];
            if (bus.addr == OFS_DW_SECOND + 8'(n)) next_rdata = dw_second[n];
            if (bus.addr == OFS_DW_CTRL + 8'(n)) next_rdata = dw_ctrl[n];
            if (bus.addr == OFS_RW_MASK + 8'(n)) next_rdata = rw_mask[n];
            if (bus.addr == OFS_RW_VALUE + 8'(n)) next_rdata = rw_value[n];
            if (bus.addr == OFS_RW_CTRL + 8'(n)) next_rdata = rw_ctrl[n];
         end
      end
   end

   // Data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (ce) begin
         rdata <= bus.rd ? next_rdata : 32'h0;
      end
   end

   //-----------------------------------------------------------
   // Checks
   //-----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_ib_disabled;
      (ib_hit & ~ib_en) == '0;
   endproperty
   a_ib_disabled: assert property (p_ib_disabled) // see RULE_03
      else $error("disabled breakpoint fired");

   property p_ib_thread;
      ib_hit[0] |-> ib_ctrl[0][TMASK_LSB + 32'(inst_obs.thread)];
   endproperty
   a_ib_thread: assert property (p_ib_thread) // see RULE_01
      else $error("breakpoint fired for masked thread");

   property p_ib_cause;
      ce && any_ib |=> cause_record[2:0] == CAUSE_IB
                     && cause_record[17:16] == lowest_index($past(ib_hit));
   endproperty
   a_ib_cause: assert property (p_ib_cause) // see RULE_16
      else $error("breakpoint cause or number wrong");

   property p_dw_capture;
      ce && !any_ib && any_dw |=> trigger_data == $past(mem_obs.addr)
                                && cause_record[2:0] == CAUSE_DW;
   endproperty
   a_dw_capture: assert property (p_dw_capture) // see RULE_15
      else $error("data watch capture wrong");

   property p_rw_capture;
      ce && !any_ib && !any_dw && any_rw |=> trigger_data == $past(res_obs.res_id)
                                          && cause_record[2:0] == CAUSE_RW;
   endproperty
   a_rw_capture: assert property (p_rw_capture) // see RULE_14
      else $error("resource watch capture wrong");

   property p_dw_and;
      dw_hit[0] && !dw_ctrl[0][CONDITION_BIT] |-> mem_obs.addr == dw_first[0]
                                              && mem_obs.addr == dw_second[0];
   endproperty
   a_dw_and: assert property (p_dw_and) // see RULE_08
      else $error("data watch AND condition broken");

   property p_status_wins;
      ce && any_ib |=> irq_status[IRQ_IB];
   endproperty
   a_status_wins: assert property (p_status_wins) // see RULE_13
      else $error("breakpoint event lost");

   property p_irq_level;
      ce && any_dw && irq_mask[IRQ_DW] && !(bus.wr && bus.addr == OFS_IRQ_MASK)
         |=> debug_irq;
   endproperty
   a_irq_level: assert property (p_irq_level) // see RULE_13
      else $error("interrupt not raised");

   property p_read;
      ce && bus.rd && bus.addr == OFS_IB_CTRL |=> rdata == $past(ib_ctrl[0]);
   endproperty
   a_read: assert property (p_read) // see RULE_01
      else $error("read data wrong");

   property p_ib_invert;
      inst_obs.valid && ib_en[1] && ib_ctrl[1][CONDITION_BIT]
         && ib_ctrl[1][TMASK_LSB + 32'(inst_obs.thread)]
         |-> ib_hit[1] == (inst_obs.pc != ib_addr[1]);
   endproperty
   a_ib_invert: assert property (p_ib_invert) // see RULE_02
      else $error("inverted compare wrong");

   property p_dw_thread;
      dw_hit[0] |-> dw_en[0] && dw_ctrl[0][TMASK_LSB + 32'(mem_obs.thread)];
   endproperty
   a_dw_thread: assert property (p_dw_thread) // see RULE_06
      else $error("data watch thread wrong");

   property p_dw_or;
      dw_hit[2] && dw_ctrl[2][CONDITION_BIT] |-> mem_obs.addr == dw_first[2]
                                              || mem_obs.addr == dw_second[2];
   endproperty
   a_dw_or: assert property (p_dw_or) // see RULE_08
      else $error("data watch OR broken");

   property p_rw_thread;
      rw_hit[0] |-> rw_en[0] && rw_ctrl[0][TMASK_LSB + 32'(res_obs.thread)];
   endproperty
   a_rw_thread: assert property (p_rw_thread) // see RULE_11
      else $error("resource watch thread wrong");

   property p_rw_select;
      rw_hit[2] |-> rw_ctrl[2][CONDITION_BIT]
                    == ((res_obs.res_id & rw_mask[2]) != (rw_value[2] & rw_mask[2]));
   endproperty
   a_rw_select: assert property (p_rw_select) // see RULE_12
      else $error("resource select broken");

   property p_ib_keeps_data;
      ce && any_ib |=> trigger_data == $past(trigger_data);
   endproperty
   a_ib_keeps_data: assert property (p_ib_keeps_data) // see RULE_15
      else $error("breakpoint changed data");

   property p_dw_number;
      ce && !any_ib && any_dw |=> cause_record[17:16] == lowest_index($past(dw_hit))
                                && cause_record[10:8] == $past(mem_obs.thread);
   endproperty
   a_dw_number: assert property (p_dw_number) // see RULE_16
      else $error("data watch number wrong");

   property p_irq_clear;
      ce && bus.wr && bus.addr == OFS_IRQ_STATUS && bus.wdata[IRQ_IB] && !any_ib
         |=> !irq_status[IRQ_IB];
   endproperty
   a_irq_clear: assert property (p_irq_clear) // see RULE_13
      else $error("status not cleared");

endmodule : breakpoint_watchpoint_unit

// File: test/core_pipeline_model.sv
`timescale 1ns/10ps
module core_pipeline_model
   import bpwp_pkg::*;
(
   input  wire logic sys_clk,
   output inst_obs_t inst_obs,
   output mem_obs_t  mem_obs,
   output res_obs_t  res_obs
);
   //--------------------------------------------------------------
   // One observation per call, held for exactly one edge
   //--------------------------------------------------------------
   initial begin
      inst_obs = '0;
      mem_obs  = '0;
      res_obs  = '0;
   end

   // Idle fields are inverted so a stale value can never pass as a match
   task automatic send(input logic [1:0] kind, input logic [2:0] thr, input logic ld,
                       input logic [31:0] v);
      @(posedge sys_clk);
      case (kind)
         2'h0: inst_obs <= '{valid: 1'b1, thread: thr, pc: v};
         2'h1: mem_obs <= '{valid: 1'b1, is_load: ld, thread: thr, addr: v};
         default: res_obs <= '{valid: 1'b1, thread: thr, res_id: v};
      endcase
      @(posedge sys_clk);
      case (kind)
         2'h0: inst_obs <= '{valid: 1'b0, thread: ~thr, pc: ~v};
         2'h1: mem_obs <= '{valid: 1'b0, is_load: ~ld, thread: ~thr, addr: ~v};
         default: res_obs <= '{valid: 1'b0, thread: ~thr, res_id: ~v};
      endcase
   endtask : send
endmodule : core_pipeline_model

// File: test/testbench.sv
`timescale 1ns/10ps
module testbench
   import bpwp_pkg::*;
;
   typedef struct packed {
      logic [1:0]  kind;
      logic [1:0]  unit;
      logic [31:0] ctrl;
      logic [31:0] r1;
      logic [31:0] r2;
      logic [2:0]  thread;
      logic        load;
      logic [31:0] obs;
      logic        hit;
   } row_t;

   localparam row_t ROWS [14] = '{
      '{2'h0, 2'h0, 32'h00010001, 32'h00001000, 32'h0, 3'h0, 1'b0, 32'h00001000, 1'b1},
      '{2'h0, 2'h1, 32'h00040003, 32'h00001000, 32'h0, 3'h2, 1'b0, 32'h00002000, 1'b1},
      '{2'h0, 2'h2, 32'h00040003, 32'h00001000, 32'h0, 3'h2, 1'b0, 32'h00001000, 1'b0},
      '{2'h0, 2'h3, 32'h00fe0001, 32'h00001000, 32'h0, 3'h0, 1'b0, 32'h00001000, 1'b0},
      '{2'h0, 2'h0, 32'h00ff0000, 32'h00001000, 32'h0, 3'h0, 1'b0, 32'h00001000, 1'b0},
      '{2'h1, 2'h0, 32'h00800005, 32'h00004000, 32'h00004000, 3'h7, 1'b1, 32'h00004000, 1'b1},
      '{2'h1, 2'h1, 32'h00800005, 32'h00004000, 32'h00004000, 3'h7, 1'b0, 32'h00004000, 1'b0},
      '{2'h1, 2'h2, 32'h00020003, 32'h00005000, 32'h00000100, 3'h1, 1'b0, 32'h00005000, 1'b1},
      '{2'h1, 2'h3, 32'h00020001, 32'h00005000, 32'h00000100, 3'h1, 1'b0, 32'h00005000, 1'b0},
      '{2'h1, 2'h3, 32'h00020003, 32'h00005000, 32'h00000100, 3'h1, 1'b0, 32'h00003000, 1'b0},
      '{2'h2, 2'h0, 32'h00100001, 32'h0000ff00, 32'h00001200, 3'h4, 1'b0, 32'h000012ab, 1'b1},
      '{2'h2, 2'h1, 32'h00100003, 32'h0000ff00, 32'h00001200, 3'h4, 1'b0, 32'h000012ab, 1'b0},
      '{2'h2, 2'h2, 32'h00100003, 32'h0000ff00, 32'h00001200, 3'h4, 1'b0, 32'h000013ab, 1'b1},
      '{2'h2, 2'h3, 32'h00080001, 32'h0000ff00, 32'h00001200, 3'h4, 1'b0, 32'h000012ab, 1'b0}
   };

   logic        sys_clk;
   logic        rst;
   logic        ce;
   bus_req_t    bus;
   logic [31:0] rdata;
   logic        debug_irq;
   inst_obs_t   inst_obs;
   mem_obs_t    mem_obs;
   res_obs_t    res_obs;
   int          fail_count;
   int          samples_checked;
   logic [7:0]  ofs_a [3] = '{OFS_IB_ADDR, OFS_DW_FIRST, OFS_RW_MASK};
   logic [7:0]  ofs_b [3] = '{OFS_IB_ADDR, OFS_DW_SECOND, OFS_RW_VALUE};
   logic [7:0]  ofs_c [3] = '{OFS_IB_CTRL, OFS_DW_CTRL, OFS_RW_CTRL};
   logic [31:0] wmask [3] = '{IB_CTRL_WMASK, DW_CTRL_WMASK, RW_CTRL_WMASK};
   logic [2:0]  causes [3] = '{CAUSE_IB, CAUSE_DW, CAUSE_RW};
   logic [7:0]  addr_ofs [5] = '{OFS_IB_ADDR, OFS_DW_FIRST, OFS_DW_SECOND, OFS_RW_MASK,
                                 OFS_RW_VALUE};

   breakpoint_watchpoint_unit i_dut (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .ce        (ce),
      .bus       (bus),
      .rdata     (rdata),
      .inst_obs  (inst_obs),
      .mem_obs   (mem_obs),
      .res_obs   (res_obs),
      .debug_irq (debug_irq)
   );

   core_pipeline_model i_obs (
      .sys_clk  (sys_clk),
      .inst_obs (inst_obs),
      .mem_obs  (mem_obs),
      .res_obs  (res_obs)
   );

   //--------------------------------------------------------------
   // Clock, bus tasks, checking
   //--------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_read

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end

   //--------------------------------------------------------------
   // Sequence
   //--------------------------------------------------------------
   initial begin
      row_t        r;
      logic [31:0] d;
      fail_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      ce = 1'b1;
      bus = '0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      #1 check(debug_irq, 0, "irq after reset");
      reg_write(OFS_IRQ_MASK, 32'h7);
      for (int i = 0; i < 14; i++) begin
         r = ROWS[i];
         reg_write(ofs_a[r.kind] + r.unit, r.r1);
         if (r.kind != 2'h0) reg_write(ofs_b[r.kind] + r.unit, r.r2);
         reg_write(ofs_c[r.kind] + r.unit, r.ctrl);
         i_obs.send(r.kind, r.thread, r.load, r.obs);
         #1 check(debug_irq, r.hit, "irq level");
         reg_read(OFS_IRQ_STATUS, d);
         check(d, 32'(r.hit) << r.kind, "status");
         if (r.hit) begin
            reg_read(OFS_CAUSE_RECORD, d);
            check(d, {14'h0, r.unit, 5'h0, r.thread, 5'h0, causes[r.kind]}, "cause");
            if (r.kind != 2'h0) begin
               reg_read(OFS_TRIGGER_DATA, d);
               check(d, r.obs, "trigger data");
            end
         end
         reg_write(OFS_IRQ_STATUS, 32'h7);
         reg_write(ofs_c[r.kind] + r.unit, 32'h0);
         $display("row %0d done", i);
      end

      // Reserved bits of each unit 0 control read back as zero
      for (int k = 0; k < 3; k++) begin
         reg_write(ofs_c[k], 32'hffffffff);
         reg_read(ofs_c[k], d);
         check(d, wmask[k], "control writable bits");
         reg_write(ofs_c[k], 32'h0);
      end
      for (int k = 0; k < 5; k++) begin
         reg_write(addr_ofs[k] + 8'h3, {24'ha5c3e1, 8'(k)});
         reg_read(addr_ofs[k] + 8'h3, d);
         check(d, {24'ha5c3e1, 8'(k)}, "address readback");
      end
      reg_write(8'hb0, 32'hffffffff);
      reg_read(8'hb0, d);
      check(d, 32'h0, "unmapped read");
      $display("register access test done");

      // Two breakpoints and a data watch hit at once, interrupt masked
      reg_write(OFS_IRQ_MASK, 32'h0);
      for (int u = 1; u < 3; u++) begin
         reg_write(OFS_IB_ADDR + 8'(u), 32'h00007000);
         reg_write(OFS_IB_CTRL + 8'(u), 32'h00200001);
      end
      reg_write(OFS_DW_FIRST, 32'h00007100);
      reg_write(OFS_DW_SECOND, 32'h00007100);
      reg_write(OFS_DW_CTRL, 32'h00200001);
      fork
         i_obs.send(2'h0, 3'h5, 1'b0, 32'h00007000);
         i_obs.send(2'h1, 3'h5, 1'b0, 32'h00007100);
      join
      #1 check(debug_irq, 0, "masked irq");
      reg_read(OFS_IRQ_STATUS, d);
      check(d, 32'h3, "both status bits");
      reg_read(OFS_CAUSE_RECORD, d);
      check(d, {14'h0, 2'h1, 5'h0, 3'h5, 5'h0, CAUSE_IB}, "lowest unit");
      reg_write(OFS_IRQ_MASK, 32'h2);
      #1 check(debug_irq, 1, "unmasked irq");
      reg_write(OFS_IRQ_STATUS, 32'h2);
      #1 check(debug_irq, 0, "irq after clear");
      reg_read(OFS_IRQ_STATUS, d);
      check(d, 32'h1, "status after clear");
      $display("priority and mask test done");

      // Reset in mid-run returns every control to zero
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      #1 check(debug_irq, 0, "irq after second reset");
      for (int k = 0; k < 3; k++) begin
         for (int u = 0; u < 4; u++) begin
            reg_read(ofs_c[k] + 8'(u), d);
            check(d, REG_RESET, "control reset");
         end
      end
      reg_read(OFS_IRQ_STATUS, d);
      check(d, REG_RESET, "status reset");
      reg_read(OFS_CAUSE_RECORD, d);
      check(d, REG_RESET, "cause reset");
      $display("reset test done");

      // Clock enable low must swallow a write
      @(posedge sys_clk);
      ce <= 1'b0;
      reg_write(OFS_IRQ_MASK, 32'h5);
      ce <= 1'b1;
      reg_read(OFS_IRQ_MASK, d);
      check(d, 32'h0, "frozen write");
      reg_write(OFS_IRQ_MASK, 32'h5);
      reg_read(OFS_IRQ_MASK, d);
      check(d, 32'h5, "enabled write");
      $display("clock enable test done");
      results();
   end
endmodule : testbench
